// >>> bench/llc_far_end.sv
module llc_far_end (
   input wire logic clock, // Bench clock
   input wire logic reset, // Synchronous, active high
   input wire logic enable, // High: send the code
   input wire logic [7:0] code, // Code pattern
   input wire logic [3:0] len, // Code length in bits
   output logic rx_clk, // Recovered clock towards the device
   output logic rx_dat // Recovered data towards the device
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div;
   logic [3:0] pos;

   always @(posedge clock) begin
      if (reset) begin
         div <= 4'h0;
         pos <= 4'h0;
         rx_clk <= 1'b0;
         rx_dat <= 1'b0;
      end else begin
         div <= (div == 4'hb) ? 4'h0 : div + 4'h1;
         if (div == 4'h6) rx_clk <= 1'b1;
         if (div == 4'h0) begin
            rx_clk <= 1'b0;
            // Line keeps clocking; without a code it alternates
            rx_dat <= enable ? code[len - 4'h1 - pos] : ~rx_dat;
            if (!enable || pos == len - 4'h1) pos <= 4'h0;
            else pos <= pos + 4'h1;
         end
      end
   end
endmodule // llc_far_end

// >>> bench/test_line_loopback_control.sv
module test_line_loopback_control;
   timeunit 1ns;
   timeprecision 1ps;
   import llc_pkg::*;
   typedef struct packed {
      logic [5:0] idx;
      logic [31:0] wd;
      logic [31:0] exp;
      logic err;
   } llc_row_t;
   logic clock = 1'b0;
   logic reset = 1'b1;
   llc_apb_req_t req = '0;
   llc_apb_rsp_t rsp;
   logic tx_clock = 1'b0, tx_data = 1'b0, master_clock = 1'b0;
   logic hw_mode = 1'b0;
   logic [1:0] pins = 2'h0;
   logic far_en = 1'b0;
   logic [7:0] far_code = 8'h00;
   logic [3:0] far_len = 4'h8;
   logic rx_clk, rx_dat;
   llc_bit_t line_tx, rx_out;
   llc_path_t loop_path;
   logic [4:0] tdiv = 5'h0;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [31:0] rd;
   logic err;
   logic [15:0] bits;
   llc_row_t rows [8] = '{
      '{LLC_IDX_TX_CODE, 32'hffffffa5, 32'h000000a5, 1'b0},
      '{LLC_IDX_RX_ACT, 32'h0000005a, 32'h0000005a, 1'b0},
      '{LLC_IDX_RX_DEACT, 32'h0000003c, 32'h0000003c, 1'b0},
      '{LLC_IDX_EDGE, 32'h00000003, 32'h00000003, 1'b0},
      '{LLC_IDX_STATUS_PRIMARY, 32'h000000ff, 32'h00000000, 1'b0},
      '{LLC_IDX_STATUS_SECONDARY, 32'h000000ff, 32'h00000000, 1'b0},
      '{6'h13, 32'h000000ff, 32'h00000000, 1'b1},
      '{LLC_IDX_LENGTH, 32'h0000003f, 32'h0000003f, 1'b0}};
   logic [7:0] codes [3] = '{8'h16, 8'h2d, 8'hb4};
   int lens [3] = '{5, 6, 8};
   logic [7:0] fill [3][3] = '{'{8'h00, 8'h01, 8'hff},
      '{8'h04, 8'h01, 8'h00}, '{8'h01, 8'h00, 8'hff}};

   llc_top #(
      .QUAL_E1_CYC(28'h14),
      .QUAL_T1_CYC(28'h1e),
      .AUTO_CYC(28'h64)
   ) i_dut (
      .clock(clock),
      .reset(reset),
      .apb_req(req),
      .apb_rsp(rsp),
      .tx_clock(tx_clock),
      .tx_data(tx_data),
      .master_clock(master_clock),
      .rx_rec_clock(rx_clk),
      .rx_rec_data(rx_dat),
      .hw_mode(hw_mode),
      .loop_select_pins(pins),
      .line_tx(line_tx),
      .rx_out(rx_out),
      .loop_path(loop_path)
   );

   llc_far_end i_far (
      .clock(clock),
      .reset(reset),
      .enable(far_en),
      .code(far_code),
      .len(far_len),
      .rx_clk(rx_clk),
      .rx_dat(rx_dat)
   );

   always #20 clock = ~clock;

   // Slow line clocks, well below a tenth of the system clock
   always @(posedge clock) begin
      tdiv <= tdiv + 5'h1;
      tx_clock <= tdiv[3];
      master_clock <= tdiv[4];
   end

   task automatic end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd);
      int i;
      @(posedge clock);
      req.psel <= 1'b1;
      req.pwrite <= wr;
      req.paddr <= {idx, 2'b00};
      req.pwdata <= wd;
      @(posedge clock);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      if (rsp.pready !== 1'b1) begin
         n_mismatch++;
         end_sim;
      end else begin
         rd = rsp.prdata;
         err = rsp.pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask

   task automatic poll(input logic [5:0] idx, input logic [31:0] mask,
                       input logic [31:0] want);
      int i;
      i = 0;
      do begin
         apb(1'b0, idx, 32'h0);
         i++;
      end while ((rd & mask) !== want && i < 600);
      chk(rd & mask, want);
      if ((rd & mask) !== want) end_sim;
   endtask

   // Collects n bits of the line (0) or receive (1) stream
   task automatic capture(input logic rx, input int n);
      int i;
      int w;
      llc_bit_t s;
      for (i = 0; i < n; i++) begin
         w = 0;
         do begin
            @(posedge clock);
            s = rx ? rx_out : line_tx;
            w++;
         end while (s.strobe !== 1'b1 && w < 200);
         if (s.strobe !== 1'b1) begin
            n_mismatch++;
            end_sim;
         end
         bits = {bits[14:0], s.data};
      end
   endtask

   // True when the stream repeats the code, MSB first, at any phase
   function automatic logic [31:0] rot_ok(logic [15:0] v, logic [7:0] c,
                                          int len);
      int k;
      int i;
      logic ok;
      rot_ok = 32'h0;
      for (k = 0; k < len; k++) begin
         ok = 1'b1;
         for (i = 0; i < 16; i++)
            if (v[15-i] !== c[len-1-((i+k)%len)]) ok = 1'b0;
         if (ok) rot_ok = 32'h1;
      end
   endfunction

   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, LLC_IDX_LOOP, 32'h0);
      chk(rd, 32'h0); // loops off
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, rows[r].idx, rows[r].wd);
         chk({31'h0, err}, {31'h0, rows[r].err});
         apb(1'b0, rows[r].idx, 32'h0);
         chk(rd, rows[r].exp);
      end
      hw_mode <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         pins <= 2'(p);
         repeat (10) @(posedge clock);
         chk(32'(loop_path), {29'h0, p == 1, p == 2, p == 3});
      end
      hw_mode <= 1'b0;
      pins <= 2'h0;
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, LLC_IDX_LOOP, 32'h1 << p);
         repeat (3) @(posedge clock);
         chk(32'(loop_path), 32'h4 >> p);
      end
      apb(1'b1, LLC_IDX_LOOP, 32'h1);
      for (int c = 0; c < 3; c++) begin
         apb(1'b1, LLC_IDX_LENGTH, 32'(lens[c] - 5));
         apb(1'b1, LLC_IDX_TX_CODE, {24'h0, codes[c]});
         apb(1'b1, LLC_IDX_PATTERN, 32'h3);
         capture(1'b0, 32);
         chk(rot_ok(bits, codes[c], lens[c]), 32'h1);
         capture(1'b1, 32);
         chk(rot_ok(bits, codes[c], lens[c]), 32'h1);
      end
      for (int f = 0; f < 3; f++) begin
         tx_data <= fill[f][1][0];
         apb(1'b1, LLC_IDX_PATTERN, {24'h0, fill[f][0]});
         capture(1'b0, 24);
         chk({24'h0, bits[7:0]}, {24'h0, fill[f][2]});
      end
      apb(1'b1, LLC_IDX_LOOP, 32'h0);
      apb(1'b1, LLC_IDX_PATTERN, 32'h0);
      apb(1'b1, LLC_IDX_RX_ACT, 32'hb4);
      apb(1'b1, LLC_IDX_RX_DEACT, 32'h1c);
      apb(1'b1, LLC_IDX_LENGTH, 32'h0c);
      // Locks left over from the looped code tests must die out first
      poll(LLC_IDX_STATUS_PRIMARY, 32'h3, 32'h0);
      apb(1'b0, LLC_IDX_FLAGS, 32'h0);
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, LLC_IDX_EDGE, 32'(e));
         far_code <= 8'hb4;
         far_len <= 4'h8;
         far_en <= 1'b1;
         poll(LLC_IDX_STATUS_PRIMARY, 32'h1, 32'h1);
         apb(1'b0, LLC_IDX_FLAGS, 32'h0);
         chk(rd & 32'h1, 32'h1);
         apb(1'b0, LLC_IDX_FLAGS, 32'h0);
         chk(rd & 32'h1, 32'h0);
         far_en <= 1'b0;
         poll(LLC_IDX_STATUS_PRIMARY, 32'h1, 32'h0);
         apb(1'b0, LLC_IDX_FLAGS, 32'h0);
         chk(rd & 32'h1, 32'(e));
      end
      apb(1'b1, LLC_IDX_MODE, 32'h1);
      far_code <= 8'h1c;
      far_len <= 4'h5;
      far_en <= 1'b1;
      poll(LLC_IDX_STATUS_PRIMARY, 32'h2, 32'h2);
      apb(1'b0, LLC_IDX_FLAGS, 32'h0);
      chk(rd & 32'h2, 32'h2);
      far_en <= 1'b0;
      poll(LLC_IDX_STATUS_PRIMARY, 32'h2, 32'h0);
      apb(1'b1, LLC_IDX_LOOP, 32'h8);
      far_code <= 8'hb4;
      far_len <= 4'h8;
      far_en <= 1'b1;
      poll(LLC_IDX_STATUS_SECONDARY, 32'h1, 32'h1);
      capture(1'b0, 32);
      chk(rot_ok(bits, 8'hb4, 8), 32'h1);
      far_en <= 1'b0;
      repeat (300) @(posedge clock);
      apb(1'b0, LLC_IDX_STATUS_SECONDARY, 32'h0);
      chk(rd & 32'h1, 32'h1); // loop holds
      far_code <= 8'h1c;
      far_len <= 4'h5;
      far_en <= 1'b1;
      poll(LLC_IDX_STATUS_SECONDARY, 32'h1, 32'h0);
      apb(1'b0, LLC_IDX_STATUS_PRIMARY, 32'h0);
      chk(rd & 32'h2, 32'h2);
      far_code <= 8'hb4;
      far_len <= 4'h8;
      poll(LLC_IDX_STATUS_SECONDARY, 32'h1, 32'h1);
      far_en <= 1'b0;
      apb(1'b1, LLC_IDX_LOOP, 32'h0);
      apb(1'b0, LLC_IDX_STATUS_SECONDARY, 32'h0);
      chk(rd & 32'h1, 32'h0);
      chk(32'(loop_path), 32'h0);
      // Reset in mid-run returns programmed registers to zero
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, LLC_IDX_EDGE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, LLC_IDX_MODE, 32'h0);
      chk(rd, 32'h0);
      chk(32'(loop_path), 32'h0);
      end_sim;
   end
endmodule // test_line_loopback_control

// >>> rtl/llc_top.sv
// How it works
// R1: Analog loop returns transmit stream to receive
// R2: Hardware pins 01/10/11 pick analog/digital/remote
// R3: Digital loop returns transmit stream to receive
// R4: Internal patterns still replace data during analog and digital loops
// R5: Remote loop sends recovered data to line
// R6: Pattern select 11 repeats the loop code
// R7: Code detection tolerates errors, any framing
// R8: Transmit code length five to eight bits
// R9: Short codes programmed as doubled patterns
// R10: Clock select 0, pattern 00 gives normal
// R11: Activate code compared with own length
// R12: Deactivate code compared with own length
// R13: Activate status after 30/40 ms qualification
// R14: Deactivate status after 30/40 ms qualification
// R15: Edge select picks rising or any change
// R16: Interrupt flags clear when read
// R17: Auto mode makes remote loop after 5.1 s
// R18: Auto mode breaks remote loop after 5.1 s
// R19: Clearing auto enable ends auto loop at once
// R20: Pattern clock: transmit clock or master clock
// R21: Clock select 1, pattern 00 sends zeros
// R22: Status drops when code no longer seen
module llc_top #(
   parameter logic [27:0] QUAL_E1_CYC = llc_pkg::LLC_QUAL_E1_CYC,
   parameter logic [27:0] QUAL_T1_CYC = llc_pkg::LLC_QUAL_T1_CYC,
   parameter logic [27:0] AUTO_CYC = llc_pkg::LLC_AUTO_CYC
) (
   input wire logic clock, // 25 MHz
   input wire logic reset, // Synchronous, active high
   input wire llc_pkg::llc_apb_req_t apb_req, // APB request
   output llc_pkg::llc_apb_rsp_t apb_rsp, // APB answer
   input wire logic tx_clock, // Transmit clock pin
   input wire logic tx_data, // Transmit data pin
   input wire logic master_clock, // Master clock pin
   input wire logic rx_rec_clock, // Recovered receive clock
   input wire logic rx_rec_data, // Recovered receive data
   input wire logic hw_mode, // High: pins choose the loop
   input wire logic [1:0] loop_select_pins, // Hardware loop select
   output llc_pkg::llc_bit_t line_tx, // Bit to waveform shaper
   output llc_pkg::llc_bit_t rx_out, // Bit to receive outputs
   output llc_pkg::llc_path_t loop_path // Active loop paths
);
   import llc_pkg::*;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] filt;
      logic [7:0] pat;
      logic [7:0] lpc;
      logic [7:0] len;
      logic [7:0] txc;
      logic [7:0] rxa;
      logic [7:0] rxd;
      logic [7:0] ies;
      logic [7:0] mode;
      logic [1:0] flags;
      logic auto_rl;
      llc_det_t [1:0] det;
      logic [7:0] hist;
      logic [2:0] txph;
      logic [14:0] prbs;
      llc_apb_rsp_t rsp;
      llc_bit_t line_tx;
      llc_bit_t rx_out;
      llc_path_t path;
   } llc_state_t;

   llc_state_t r;
   llc_state_t n;
   logic [7:0] raw;
   logic [7:0] agree;
   logic [7:0] rise;
   logic [1:0] psel;
   logic pclk;
   logic gen;
   logic pstb;
   logic [3:0] clen;
   logic [7:0] code;
   logic [1:0] ev;
   logic [1:0] fire;
   logic [27:0] qual;
   logic rbit;
   logic take;
   logic done;
   logic rc;
   logic hit;
   logic [5:0] idx;
   logic [31:0] rdv;
   logic [7:0] wd;

   function automatic logic [3:0] code_len(input logic [1:0] sel);
      return LLC_MIN_LEN + {2'h0, sel};
   endfunction

   function automatic logic [7:0] code_mask(input logic [3:0] l);
      return 8'hff >> (4'h8 - l);
   endfunction

   function automatic logic code_bit(input logic [7:0] c,
         input logic [3:0] l, input logic [2:0] ph);
      logic [3:0] i;
      i = l - 4'h1 - {1'h0, ph};
      return c[i[2:0]];
   endfunction

   function automatic logic [2:0] next_ph(input logic [2:0] ph,
         input logic [3:0] l);
      return ({1'h0, ph} == l - 4'h1) ? 3'h0 : ph + 3'h1;
   endfunction

   assign raw = {loop_select_pins, hw_mode, rx_rec_data, rx_rec_clock,
      master_clock, tx_data, tx_clock};
   assign apb_rsp = r.rsp;
   assign line_tx = r.line_tx;
   assign rx_out = r.rx_out;
   assign loop_path = r.path;

   always_comb begin
      n = r;
      n.s1 = raw;
      n.s2 = r.s1;
      n.s3 = r.s2;
      // A change counts once the last two stages agree
      agree = ~(r.s2 ^ r.s3);
      n.filt = (agree & r.s3) | (~agree & r.filt);
      rise = n.filt & ~r.filt;

      // R19: auto loop torn down when disabled
      if (!r.lpc[LLC_LP_AUTO_BIT]) begin
         n.auto_rl = 1'b0;
      end
      // R2: hardware pins choose the loop
      if (r.filt[LLC_IN_HW]) begin
         n.path.analog = r.filt[LLC_IN_LP+:2] == LLC_PINS_ANALOG;
         n.path.digital = r.filt[LLC_IN_LP+:2] == LLC_PINS_DIGITAL;
         n.path.remote = r.filt[LLC_IN_LP+:2] == LLC_PINS_REMOTE;
      end else begin
         n.path.analog = r.lpc[LLC_LP_ANALOG_BIT];
         n.path.digital = r.lpc[LLC_LP_DIGITAL_BIT];
         n.path.remote = r.lpc[LLC_LP_REMOTE_BIT];
      end
      n.path.remote = n.path.remote | r.auto_rl;

      psel = r.pat[LLC_PAT_SEL_LSB+:2];
      pclk = r.pat[LLC_PAT_CLK_BIT];
      // R10: normal data only with clock select 0 and 00
      gen = (psel != LLC_PAT_NORMAL) | pclk;
      // R20: pattern clock source
      pstb = pclk ? rise[LLC_IN_MCLK] : rise[LLC_IN_TX_CLOCK];
      clen = code_len(r.len[LLC_LEN_TX_LSB+:2]);
      n.line_tx = '0;
      if (n.path.remote) begin
         // R5: recovered stream back to the line
         n.line_tx.strobe = rise[LLC_IN_RCLK];
         n.line_tx.data = r.filt[LLC_IN_RDAT];
      end else if (gen) begin
         // R4: patterns overwrite data, analog and digital loops included
         n.line_tx.strobe = pstb;
         case (psel)
            // R21: all zeros
            LLC_PAT_NORMAL: n.line_tx.data = 1'b0;
            LLC_PAT_ONES: n.line_tx.data = 1'b1;
            LLC_PAT_PRBS: n.line_tx.data = r.prbs[14];
            // R6: repeated loop code, R8 length
            default: n.line_tx.data = code_bit(r.txc, clen, r.txph);
         endcase
      end else begin
         n.line_tx.strobe = rise[LLC_IN_TX_CLOCK];
         n.line_tx.data = r.filt[LLC_IN_TDAT];
      end
      if (gen && pstb && !n.path.remote) begin
         n.prbs = {r.prbs[13:0],
            (r.prbs[14] ^ r.prbs[13]) | (r.prbs == 15'h0)};
         n.txph = next_ph(r.txph, clen);
      end
      if (psel != LLC_PAT_CODE) begin
         n.txph = 3'h0;
      end

      // R1: analog loop, R3: digital loop
      if (n.path.analog || n.path.digital) begin
         n.rx_out = n.line_tx;
      end else begin
         n.rx_out.strobe = rise[LLC_IN_RCLK];
         n.rx_out.data = r.filt[LLC_IN_RDAT];
      end

      rbit = n.rx_out.data;
      if (n.rx_out.strobe) begin
         n.hist = {r.hist[6:0], rbit};
      end
      qual = r.mode[LLC_MODE_E1_BIT] ? QUAL_E1_CYC : QUAL_T1_CYC;
      ev = 2'h0;
      fire = 2'h0;
      code = 8'h0;
      clen = 4'h0;
      for (int i = 0; i < 2; i++) begin
         // R11: activate code, R12: deactivate code, R9 doubled
         code = (i == 0) ? r.rxa : r.rxd;
         clen = code_len((i == 0) ? r.len[LLC_LEN_ACT_LSB+:2] :
            r.len[LLC_LEN_DEACT_LSB+:2]);
         if (n.rx_out.strobe) begin
            // R7: phase-free lock, errors tolerated per block
            if (!r.det[i].locked) begin
               if (((n.hist ^ code) & code_mask(clen)) == 8'h0) begin
                  n.det[i].locked = 1'b1;
                  n.det[i].phase = 3'h0;
                  n.det[i].errs = 3'h0;
                  n.det[i].nbits = 6'h0;
               end
            end else begin
               n.det[i].phase = next_ph(r.det[i].phase, clen);
               n.det[i].nbits = r.det[i].nbits + 6'h1;
               if (r.det[i].nbits == LLC_BLOCK_LAST) begin
                  n.det[i].errs = 3'h0;
               end
               if (rbit != code_bit(code, clen, r.det[i].phase)) begin
                  if (r.det[i].errs == LLC_ERR_LIMIT) begin
                     n.det[i].locked = 1'b0;
                  end else if (r.det[i].nbits != LLC_BLOCK_LAST) begin
                     n.det[i].errs = r.det[i].errs + 3'h1;
                  end else begin
                     n.det[i].errs = 3'h1;
                  end
               end
            end
         end
         if (n.det[i].locked) begin
            if (r.det[i].dur < qual) begin
               n.det[i].dur = r.det[i].dur + 28'h1;
            end
            if (r.det[i].acnt < AUTO_CYC) begin
               n.det[i].acnt = r.det[i].acnt + 28'h1;
            end
         end else begin
            n.det[i].dur = 28'h0;
            n.det[i].acnt = 28'h0;
         end
         // R13: activate, R14: deactivate, R22: drop
         n.det[i].seen = n.det[i].locked && (n.det[i].dur >= qual);
         fire[i] = (n.det[i].acnt >= AUTO_CYC) &&
            (r.det[i].acnt < AUTO_CYC);
         // R15: rising or any change
         ev[i] = r.ies[i] ? (n.det[i].seen ^ r.det[i].seen) :
            (n.det[i].seen & ~r.det[i].seen);
      end
      if (r.lpc[LLC_LP_AUTO_BIT]) begin
         // R18: deactivate wins over activate
         if (fire[LLC_DEACT_BIT]) begin
            n.auto_rl = 1'b0;
         end else if (fire[LLC_ACT_BIT]) begin
            // R17: establish and hold
            n.auto_rl = 1'b1;
         end
      end

      // APB slave: answer on the second access cycle
      idx = apb_req.paddr[7:2];
      take = apb_req.psel && apb_req.penable && !r.rsp.pready;
      done = apb_req.psel && apb_req.penable && r.rsp.pready;
      hit = 1'b1;
      rdv = 32'h0;
      if (apb_req.paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (idx == LLC_IDX_PATTERN) begin
         rdv[7:0] = r.pat;
      end else if (idx == LLC_IDX_LOOP) begin
         rdv[7:0] = r.lpc;
      end else if (idx == LLC_IDX_LENGTH) begin
         rdv[7:0] = r.len;
      end else if (idx == LLC_IDX_TX_CODE) begin
         rdv[7:0] = r.txc;
      end else if (idx == LLC_IDX_RX_ACT) begin
         rdv[7:0] = r.rxa;
      end else if (idx == LLC_IDX_RX_DEACT) begin
         rdv[7:0] = r.rxd;
      end else if (idx == LLC_IDX_EDGE) begin
         rdv[7:0] = r.ies;
      end else if (idx == LLC_IDX_STATUS_PRIMARY) begin
         rdv[LLC_ACT_BIT] = r.det[0].seen;
         rdv[LLC_DEACT_BIT] = r.det[1].seen;
      end else if (idx == LLC_IDX_STATUS_SECONDARY) begin
         rdv[LLC_REMOTE_ST_BIT] = r.path.remote;
      end else if (idx == LLC_IDX_FLAGS) begin
         rdv[1:0] = r.flags;
      end else if (idx == LLC_IDX_MODE) begin
         rdv[7:0] = r.mode;
      end else begin
         hit = 1'b0;
      end
      n.rsp = '0;
      if (take) begin
         n.rsp.pready = 1'b1;
         n.rsp.pslverr = !hit;
         n.rsp.prdata = apb_req.pwrite ? 32'h0 : rdv;
      end
      wd = apb_req.pwdata[7:0];
      if (done && apb_req.pwrite && hit) begin
         if (idx == LLC_IDX_PATTERN) begin
            n.pat = wd;
         end else if (idx == LLC_IDX_LOOP) begin
            n.lpc = wd;
         end else if (idx == LLC_IDX_LENGTH) begin
            n.len = wd;
         end else if (idx == LLC_IDX_TX_CODE) begin
            n.txc = wd;
         end else if (idx == LLC_IDX_RX_ACT) begin
            n.rxa = wd;
         end else if (idx == LLC_IDX_RX_DEACT) begin
            n.rxd = wd;
         end else if (idx == LLC_IDX_EDGE) begin
            n.ies = wd;
         end else if (idx == LLC_IDX_MODE) begin
            n.mode = wd;
         end
      end
      // R16: clear on read; only bits returned, new events win
      rc = done && !apb_req.pwrite && hit && (idx == LLC_IDX_FLAGS);
      n.flags = ev | (r.flags & ~({2{rc}} & r.rsp.prdata[1:0]));
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   AST_LOOP_RX: assert property ( // R1
      (r.path.analog || r.path.digital) |->
         (r.rx_out == r.line_tx))
      else $error("Loop path does not mirror transmit stream");
   AST_HW_PINS: assert property ( // R2
      r.filt[LLC_IN_HW] && r.filt[LLC_IN_LP+:2] == LLC_PINS_DIGITAL
         |=> loop_path.digital && !loop_path.analog)
      else $error("Hardware pins 10 did not select digital loop");
   AST_REMOTE_TX: assert property ( // R5
      n.path.remote && rise[LLC_IN_RCLK] |=>
         line_tx.strobe && line_tx.data == $past(r.filt[LLC_IN_RDAT]))
      else $error("Remote loop did not send recovered bit");
   AST_ONES_TX: assert property ( // R20
      line_tx.strobe && !loop_path.remote &&
         $past(r.pat[2:0]) == 3'h1 |-> line_tx.data &&
         $past(rise[LLC_IN_TX_CLOCK]))
      else $error("All ones not sent on transmit clock edge");
   AST_ZERO_TX: assert property ( // R21
      line_tx.strobe && !loop_path.remote && $past(r.pat[2:0]) == 3'h4
         |-> !line_tx.data && $past(rise[LLC_IN_MCLK]))
      else $error("All zeros not sent on master clock edge");
   AST_QUAL: assert property ( // R13
      $rose(r.det[0].seen) |-> r.det[0].dur >=
         ($past(r.mode[LLC_MODE_E1_BIT]) ? QUAL_E1_CYC : QUAL_T1_CYC))
      else $error("Activate status set before qualification");
   AST_DROP: assert property ( // R22
      !r.det[1].locked |-> !r.det[1].seen)
      else $error("Deactivate status held without detection");
   AST_EDGE: assert property ( // R15
      $fell(r.det[0].seen) && $past(r.ies[0]) |-> r.flags[0])
      else $error("Falling status not flagged in any-change mode");
   AST_RC: assert property ( // R16
      rc && r.rsp.prdata[0] |=>
         !r.flags[0] || $changed(r.det[0].seen))
      else $error("Read flag not cleared");
   AST_AUTO_OFF: assert property ( // R19
      !r.lpc[LLC_LP_AUTO_BIT] |=> !r.auto_rl)
      else $error("Auto loop survived disable");

   COV_AUTO: cover property ($rose(r.auto_rl));
   COV_FLAG: cover property ($rose(r.flags[1]));
   COV_CODE: cover property (line_tx.strobe && r.pat[1:0] == 2'h3);
   COV_ANALOG: cover property (loop_path.analog && rx_out.strobe);
endmodule // llc_top

// >>> shared/llc_pkg.sv
package llc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] LLC_IDX_PATTERN = 6'h0d;
   localparam logic [5:0] LLC_IDX_LOOP = 6'h0e;
   localparam logic [5:0] LLC_IDX_LENGTH = 6'h0f;
   localparam logic [5:0] LLC_IDX_TX_CODE = 6'h10;
   localparam logic [5:0] LLC_IDX_RX_ACT = 6'h11;
   localparam logic [5:0] LLC_IDX_RX_DEACT = 6'h12;
   localparam logic [5:0] LLC_IDX_EDGE = 6'h16;
   localparam logic [5:0] LLC_IDX_STATUS_PRIMARY = 6'h17;
   localparam logic [5:0] LLC_IDX_STATUS_SECONDARY = 6'h18;
   localparam logic [5:0] LLC_IDX_FLAGS = 6'h19;
   localparam logic [5:0] LLC_IDX_MODE = 6'h20;

   // Field positions
   localparam int LLC_PAT_SEL_LSB = 0;
   localparam int LLC_PAT_CLK_BIT = 2;
   localparam int LLC_LP_ANALOG_BIT = 0;
   localparam int LLC_LP_DIGITAL_BIT = 1;
   localparam int LLC_LP_REMOTE_BIT = 2;
   localparam int LLC_LP_AUTO_BIT = 3;
   localparam int LLC_LEN_TX_LSB = 0;
   localparam int LLC_LEN_ACT_LSB = 2;
   localparam int LLC_LEN_DEACT_LSB = 4;
   localparam int LLC_ACT_BIT = 0;
   localparam int LLC_DEACT_BIT = 1;
   localparam int LLC_REMOTE_ST_BIT = 0;
   localparam int LLC_MODE_E1_BIT = 0;

   // Synchronised input bundle positions
   localparam int LLC_IN_TX_CLOCK = 0;
   localparam int LLC_IN_TDAT = 1;
   localparam int LLC_IN_MCLK = 2;
   localparam int LLC_IN_RCLK = 3;
   localparam int LLC_IN_RDAT = 4;
   localparam int LLC_IN_HW = 5;
   localparam int LLC_IN_LP = 6;

   // Encodings
   localparam logic [1:0] LLC_PAT_NORMAL = 2'h0;
   localparam logic [1:0] LLC_PAT_ONES = 2'h1;
   localparam logic [1:0] LLC_PAT_PRBS = 2'h2;
   localparam logic [1:0] LLC_PAT_CODE = 2'h3;
   localparam logic [1:0] LLC_PINS_ANALOG = 2'h1;
   localparam logic [1:0] LLC_PINS_DIGITAL = 2'h2;
   localparam logic [1:0] LLC_PINS_REMOTE = 2'h3;

   // Code detection
   localparam logic [3:0] LLC_MIN_LEN = 4'h5;
   localparam logic [5:0] LLC_BLOCK_LAST = 6'h3f;
   localparam logic [2:0] LLC_ERR_LIMIT = 3'h6;
   localparam logic [7:0] LLC_REG_RST = 8'h00;

   // Timing
   localparam int LLC_CLK_KHZ = 25000;
   localparam int LLC_QUAL_E1_MS = 30;
   localparam int LLC_QUAL_T1_MS = 40;
   localparam int LLC_AUTO_MS = 5100;
   localparam int LLC_CNT_W = 28;
   localparam logic [LLC_CNT_W-1:0] LLC_QUAL_E1_CYC =
      28'(LLC_QUAL_E1_MS * LLC_CLK_KHZ);
   localparam logic [LLC_CNT_W-1:0] LLC_QUAL_T1_CYC =
      28'(LLC_QUAL_T1_MS * LLC_CLK_KHZ);
   localparam logic [LLC_CNT_W-1:0] LLC_AUTO_CYC =
      28'(LLC_AUTO_MS * LLC_CLK_KHZ);

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } llc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } llc_apb_rsp_t;

   typedef struct packed {
      logic strobe;
      logic data;
   } llc_bit_t;

   typedef struct packed {
      logic analog;
      logic digital;
      logic remote;
   } llc_path_t;

   typedef struct packed {
      logic locked;
      logic [2:0] phase;
      logic [2:0] errs;
      logic [5:0] nbits;
      logic [LLC_CNT_W-1:0] dur;
      logic [LLC_CNT_W-1:0] acnt;
      logic seen;
   } llc_det_t;
endpackage
